// *** verilog/vlan_filter_pkg.sv ***
// Constants, field layouts and types of the VLAN membership filter.
// Assumes a single core clock; shared by all filter modules.
package vlan_filter_pkg;

	localparam int NUM_PORTS = 10;
	localparam int PORT_W = 4;
	localparam int VID_W = 12;
	localparam int TBL_DEPTH = 256;
	localparam int TBL_IDX_W = 8;
	localparam int GRP_W = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	typedef enum logic [1:0] {
		MODE_DISABLED = 2'h0,
		MODE_PORT = 2'h1,
		MODE_TAG = 2'h2
	} vlan_mode_t;

	typedef enum logic [1:0] {
		LINK_ACCESS = 2'h0,
		LINK_TRUNK = 2'h1,
		LINK_HYBRID = 2'h2
	} link_type_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SCAN = 3'b010,
		ST_DONE = 3'b100
	} filter_state_t;

	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_TBL_INDEX = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_TBL_DATA = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_PORT_BASE = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_PORT_LAST = 8'h64;

	// Field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_GVRP_BIT = 2;
	localparam int CTRL_GVRP_ACT_BIT = 3;
	localparam int STAT_REJ_DEFAULT_BIT = 0;
	localparam int STAT_BAD_LINK_BIT = 1;
	localparam int STAT_BUSY_BIT = 8;
	localparam int TBL_VID_LSB = 0;
	localparam int TBL_MEMBER_LSB = 12;
	localparam int TBL_VALID_BIT = 31;
	localparam int PORT_UVID_LSB = 0;
	localparam int PORT_LINK_LSB = 12;
	localparam int PORT_GROUP_LSB = 16;

	// Values after reset and fixed entries
	localparam vlan_mode_t RST_MODE = MODE_DISABLED;
	localparam link_type_t RST_LINK = LINK_ACCESS;
	localparam logic [VID_W-1:0] DEFAULT_VID = 12'h001;
	localparam logic [TBL_IDX_W-1:0] DEFAULT_IDX = 8'h00;
	localparam logic [TBL_IDX_W-1:0] LAST_IDX = 8'hFF;
	localparam logic [GRP_W-1:0] RST_GROUP = 4'h0;
	localparam logic [NUM_PORTS-1:0] ALL_PORTS = 10'h3FF;

endpackage : vlan_filter_pkg

// *** verilog/vlan_table_if.sv ***
// Connection between the filter control and its VLAN table store.
// Assumes both ends run on core_clk; reads are combinational.
`timescale 1ns/1ps
interface vlan_table_if;
	logic wrEn;
	logic [vlan_filter_pkg::TBL_IDX_W-1:0] wrIdx;
	logic [vlan_filter_pkg::VID_W-1:0] wrVid;
	logic [vlan_filter_pkg::NUM_PORTS-1:0] wrMembers;
	logic wrValid;
	logic [vlan_filter_pkg::TBL_IDX_W-1:0] scanIdx;
	logic [vlan_filter_pkg::VID_W-1:0] scanVid;
	logic [vlan_filter_pkg::NUM_PORTS-1:0] scanMembers;
	logic scanValid;
	logic [vlan_filter_pkg::TBL_IDX_W-1:0] swIdx;
	logic [vlan_filter_pkg::VID_W-1:0] swVid;
	logic [vlan_filter_pkg::NUM_PORTS-1:0] swMembers;
	logic swValid;

	modport store (
		input wrEn, wrIdx, wrVid, wrMembers, wrValid, scanIdx, swIdx,
		output scanVid, scanMembers, scanValid, swVid, swMembers, swValid
	);
	modport ctrl (
		output wrEn, wrIdx, wrVid, wrMembers, wrValid, scanIdx, swIdx,
		input scanVid, scanMembers, scanValid, swVid, swMembers, swValid
	);
endinterface : vlan_table_if

// *** verilog/vlan_table_store.sv ***
// Storage of the tag-based VLAN table: identifier, members, valid.
// Assumes one writer per cycle from the filter control.
`timescale 1ns/1ps
module vlan_table_store (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Table access
	vlan_table_if.store tbl
);
	logic [vlan_filter_pkg::VID_W-1:0] vidMem [vlan_filter_pkg::TBL_DEPTH];
	logic [vlan_filter_pkg::NUM_PORTS-1:0]
		memberMem [vlan_filter_pkg::TBL_DEPTH];
	logic [vlan_filter_pkg::TBL_DEPTH-1:0] entryValid;

	// Only the valid bits need a reset; contents are ignored while invalid
	always_ff @(posedge core_clk)
	begin
		if (tbl.wrEn)
		begin
			vidMem[tbl.wrIdx] <= tbl.wrVid;
			memberMem[tbl.wrIdx] <= tbl.wrMembers;
		end
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			entryValid <= '0;
		else if (tbl.wrEn)
			entryValid[tbl.wrIdx] <= tbl.wrValid;
	end

	assign tbl.scanVid = vidMem[tbl.scanIdx];
	assign tbl.scanMembers = memberMem[tbl.scanIdx];
	assign tbl.scanValid = entryValid[tbl.scanIdx];
	assign tbl.swVid = vidMem[tbl.swIdx];
	assign tbl.swMembers = memberMem[tbl.swIdx];
	assign tbl.swValid = entryValid[tbl.swIdx];
endmodule : vlan_table_store

// *** verilog/port_group_filter.sv ***
// Port-based grouping: marks each port in the ingress port's group.
// Assumes group 0 stands for all ports left unassigned.
`timescale 1ns/1ps
module port_group_filter (
	// Group of every port
	input wire logic [vlan_filter_pkg::NUM_PORTS-1:0]
		[vlan_filter_pkg::GRP_W-1:0] portGroup,
	// Frame source
	input wire logic [vlan_filter_pkg::PORT_W-1:0] ingressPort,
	// Result
	output logic [vlan_filter_pkg::NUM_PORTS-1:0] sameGroup
);
	logic [vlan_filter_pkg::GRP_W-1:0] ingressGroup;

	assign ingressGroup = portGroup[ingressPort];

	genvar p;
	generate
		for (p = 0; p < vlan_filter_pkg::NUM_PORTS; p++)
		begin : g_port
			// Unassigned ports share group 0, so they meet only each other
			assign sameGroup[p] = (portGroup[p] == ingressGroup);
		end
	endgenerate
endmodule : port_group_filter

// *** verilog/vlan_membership_filter.sv ***
// VLAN classification and forwarding filter for a ten-port switch.
// Assumes frame descriptors and register strobes synchronous to core_clk.
//
// Overview of operation
// - Mode is disabled, port-based or tag-based; disabled after reset.
// - Port-based: forward only to ports of the ingress port's group.
// - Ungrouped ports form one extra group and reach only each other.
// - Port-based mode ignores any VLAN tag of received frames.
// - Tag-based: a frame's VLAN is the identifier in its tag.
// - The VLAN table holds up to 256 groups.
// - Entering tag-based mode makes every port a member of VLAN 1.
// - Removing the default VLAN from the table is refused.
// - GVRP enable acts only in tag-based mode.
// - Link type per port: access, trunk or hybrid, nothing else.
// - Access ports use only their untagged identifier.
// - Trunk ports use only their tagged identifiers.
// - Hybrid ports use untagged and tagged identifiers together.
// - Untagged frames take the port identifier, on trunk ports VLAN 1; tagged need membership.
`timescale 1ns/1ps
module vlan_membership_filter (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Register port
	input wire logic [vlan_filter_pkg::ADDR_W-1:0] regAddr,
	input wire logic [vlan_filter_pkg::DATA_W-1:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [vlan_filter_pkg::DATA_W-1:0] regRdData,
	// Frame descriptor in
	input wire logic inValid,
	output logic inReady,
	input wire logic [vlan_filter_pkg::PORT_W-1:0] inPort,
	input wire logic inTagged,
	input wire logic [vlan_filter_pkg::VID_W-1:0] inVid,
	input wire logic [vlan_filter_pkg::NUM_PORTS-1:0] inCandidates,
	// Forwarding decision out
	output logic outValid,
	output logic [vlan_filter_pkg::NUM_PORTS-1:0] outEgress,
	output logic [vlan_filter_pkg::VID_W-1:0] outVid,
	output logic outDrop,
	// Protocol control
	output logic gvrpActive
);
	localparam int NP = vlan_filter_pkg::NUM_PORTS;
	localparam int VW = vlan_filter_pkg::VID_W;

	vlan_filter_pkg::vlan_mode_t mode;
	logic gvrpEnable;
	logic rejDefault;
	logic badLink;
	logic [vlan_filter_pkg::TBL_IDX_W-1:0] tblIndex;
	logic [NP-1:0][VW-1:0] untagVid;
	vlan_filter_pkg::link_type_t [NP-1:0] linkType;
	logic [NP-1:0][vlan_filter_pkg::GRP_W-1:0] portGroup;

	vlan_filter_pkg::filter_state_t state;
	vlan_filter_pkg::vlan_mode_t frmMode;
	logic [vlan_filter_pkg::PORT_W-1:0] frmPort;
	logic frmBadPort;
	logic frmTagged;
	logic [VW-1:0] frmVid;
	logic [NP-1:0] frmCand;
	logic [NP-1:0] frmMembers;
	logic [vlan_filter_pkg::TBL_IDX_W-1:0] scanIdx;

	logic [NP-1:0] sameGroup;
	logic [NP-1:0] egressOk;
	logic ingressOk;
	logic nextDrop;
	logic inPortOk;
	logic [VW-1:0] next_frmVid;
	logic enterTag;
	logic ctrlWrite;
	logic tblWrite;
	logic removesDefault;
	logic portWrite;
	logic [vlan_filter_pkg::PORT_W-1:0] wrPort;
	logic [1:0] wrMode;
	logic [1:0] wrLink;

	vlan_table_if tbl ();

	vlan_table_store u_store (
		.core_clk(core_clk),
		.reset(reset),
		.tbl(tbl)
	);

	port_group_filter u_group (
		.portGroup(portGroup),
		.ingressPort(frmPort),
		.sameGroup(sameGroup)
	);

	// Address of one of the per-port configuration words
	function automatic logic isPortAddr(
		input logic [vlan_filter_pkg::ADDR_W-1:0] a);
		return (a >= vlan_filter_pkg::OFS_PORT_BASE) &&
			(a <= vlan_filter_pkg::OFS_PORT_LAST) && (a[1:0] == 2'h0);
	endfunction : isPortAddr

	function automatic logic [vlan_filter_pkg::PORT_W-1:0] portOf(
		input logic [vlan_filter_pkg::ADDR_W-1:0] a);
		logic [vlan_filter_pkg::ADDR_W-1:0] d;
		d = a - vlan_filter_pkg::OFS_PORT_BASE;
		return d[5:2];
	endfunction : portOf

	// Membership of one port in a VLAN according to its link type
	function automatic logic isMember(
		input vlan_filter_pkg::link_type_t lt,
		input logic [VW-1:0] uvid,
		input logic tblBit,
		input logic [VW-1:0] vid);
		case (lt)
			vlan_filter_pkg::LINK_ACCESS: return uvid == vid;
			vlan_filter_pkg::LINK_TRUNK: return tblBit;
			vlan_filter_pkg::LINK_HYBRID: return (uvid == vid) || tblBit;
			default: return 1'b0;
		endcase
	endfunction : isMember

	assign wrMode = regWrData[vlan_filter_pkg::CTRL_MODE_LSB +: 2];
	assign wrLink = regWrData[vlan_filter_pkg::PORT_LINK_LSB +: 2];
	assign wrPort = portOf(regAddr);
	assign ctrlWrite = regWrite && (regAddr == vlan_filter_pkg::OFS_CTRL);
	assign portWrite = regWrite && isPortAddr(regAddr);
	assign tblWrite = regWrite && (regAddr == vlan_filter_pkg::OFS_TBL_DATA);
	assign enterTag = ctrlWrite &&
		(wrMode == vlan_filter_pkg::MODE_TAG) &&
		(mode != vlan_filter_pkg::MODE_TAG);
	assign removesDefault = tblWrite &&
		(tblIndex == vlan_filter_pkg::DEFAULT_IDX) &&
		(!regWrData[vlan_filter_pkg::TBL_VALID_BIT] ||
		(regWrData[vlan_filter_pkg::TBL_VID_LSB +: VW] !=
		vlan_filter_pkg::DEFAULT_VID));

	// Table writes: the default entry on entry to tag mode, else software
	always_comb
	begin
		tbl.wrEn = 1'b0;
		tbl.wrIdx = tblIndex;
		tbl.wrVid = regWrData[vlan_filter_pkg::TBL_VID_LSB +: VW];
		tbl.wrMembers = regWrData[vlan_filter_pkg::TBL_MEMBER_LSB +: NP];
		tbl.wrValid = regWrData[vlan_filter_pkg::TBL_VALID_BIT];
		if (enterTag)
		begin
			tbl.wrEn = 1'b1;
			tbl.wrIdx = vlan_filter_pkg::DEFAULT_IDX;
			tbl.wrVid = vlan_filter_pkg::DEFAULT_VID;
			tbl.wrMembers = vlan_filter_pkg::ALL_PORTS;
			tbl.wrValid = 1'b1;
		end
		else if (tblWrite && !removesDefault)
			tbl.wrEn = 1'b1;
	end

	assign tbl.swIdx = tblIndex;
	assign tbl.scanIdx = scanIdx;

	// Operating mode and GVRP enable; unencodable modes are ignored
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			mode <= vlan_filter_pkg::RST_MODE;
			gvrpEnable <= 1'b0;
		end
		else if (ctrlWrite)
		begin
			if (wrMode != 2'h3)
				mode <= vlan_filter_pkg::vlan_mode_t'(wrMode);
			gvrpEnable <= regWrData[vlan_filter_pkg::CTRL_GVRP_BIT];
		end
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			gvrpActive <= 1'b0;
		else
			gvrpActive <= gvrpEnable &&
				(mode == vlan_filter_pkg::MODE_TAG);
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			tblIndex <= '0;
		else if (regWrite && (regAddr == vlan_filter_pkg::OFS_TBL_INDEX))
			tblIndex <= regWrData[vlan_filter_pkg::TBL_IDX_W-1:0];
	end

	// Per-port configuration; a fourth link code leaves the old type
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			for (int p = 0; p < NP; p++)
			begin
				untagVid[p] <= vlan_filter_pkg::DEFAULT_VID;
				linkType[p] <= vlan_filter_pkg::RST_LINK;
				portGroup[p] <= vlan_filter_pkg::RST_GROUP;
			end
		end
		else if (enterTag)
		begin
			for (int p = 0; p < NP; p++)
				untagVid[p] <= vlan_filter_pkg::DEFAULT_VID;
		end
		else if (portWrite)
		begin
			untagVid[wrPort] <=
				regWrData[vlan_filter_pkg::PORT_UVID_LSB +: VW];
			if (wrLink != 2'h3)
				linkType[wrPort] <=
					vlan_filter_pkg::link_type_t'(wrLink);
			portGroup[wrPort] <=
				regWrData[vlan_filter_pkg::PORT_GROUP_LSB +:
				vlan_filter_pkg::GRP_W];
		end
	end

	// Sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			rejDefault <= 1'b0;
			badLink <= 1'b0;
		end
		else
		begin
			if (removesDefault)
				rejDefault <= 1'b1;
			else if (regWrite && (regAddr == vlan_filter_pkg::OFS_STATUS) &&
				regWrData[vlan_filter_pkg::STAT_REJ_DEFAULT_BIT])
				rejDefault <= 1'b0;
			if (portWrite && (wrLink == 2'h3))
				badLink <= 1'b1;
			else if (regWrite && (regAddr == vlan_filter_pkg::OFS_STATUS) &&
				regWrData[vlan_filter_pkg::STAT_BAD_LINK_BIT])
				badLink <= 1'b0;
		end
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			regRdData <= '0;
		else if (!regRead)
			regRdData <= '0;
		else if (regAddr == vlan_filter_pkg::OFS_CTRL)
		begin
			regRdData <= '0;
			regRdData[vlan_filter_pkg::CTRL_MODE_LSB +: 2] <= mode;
			regRdData[vlan_filter_pkg::CTRL_GVRP_BIT] <= gvrpEnable;
			regRdData[vlan_filter_pkg::CTRL_GVRP_ACT_BIT] <= gvrpActive;
		end
		else if (regAddr == vlan_filter_pkg::OFS_STATUS)
		begin
			regRdData <= '0;
			regRdData[vlan_filter_pkg::STAT_REJ_DEFAULT_BIT] <= rejDefault;
			regRdData[vlan_filter_pkg::STAT_BAD_LINK_BIT] <= badLink;
			regRdData[vlan_filter_pkg::STAT_BUSY_BIT] <=
				(state != vlan_filter_pkg::ST_IDLE);
		end
		else if (regAddr == vlan_filter_pkg::OFS_TBL_INDEX)
		begin
			regRdData <= '0;
			regRdData[vlan_filter_pkg::TBL_IDX_W-1:0] <= tblIndex;
		end
		else if (regAddr == vlan_filter_pkg::OFS_TBL_DATA)
		begin
			regRdData <= '0;
			regRdData[vlan_filter_pkg::TBL_VID_LSB +: VW] <= tbl.swVid;
			regRdData[vlan_filter_pkg::TBL_MEMBER_LSB +: NP] <= tbl.swMembers;
			regRdData[vlan_filter_pkg::TBL_VALID_BIT] <= tbl.swValid;
		end
		else if (isPortAddr(regAddr))
		begin
			regRdData <= '0;
			regRdData[vlan_filter_pkg::PORT_UVID_LSB +: VW] <=
				untagVid[wrPort];
			regRdData[vlan_filter_pkg::PORT_LINK_LSB +: 2] <= linkType[wrPort];
			regRdData[vlan_filter_pkg::PORT_GROUP_LSB +:
				vlan_filter_pkg::GRP_W] <= portGroup[wrPort];
		end
		else
			regRdData <= '0;
	end

	// Classification of an arriving frame
	assign inPortOk = inPort < vlan_filter_pkg::PORT_W'(NP);
	always_comb
	begin
		next_frmVid = '0;
		if (!inPortOk)
			next_frmVid = '0;
		else if (inTagged)
			next_frmVid = inVid;
		else if (linkType[inPort] == vlan_filter_pkg::LINK_TRUNK)
			next_frmVid = vlan_filter_pkg::DEFAULT_VID;
		else
			next_frmVid = untagVid[inPort];
	end

	// Frame sequencing; the table search walks one entry per cycle
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			state <= vlan_filter_pkg::ST_IDLE;
			inReady <= 1'b1;
			frmMode <= vlan_filter_pkg::RST_MODE;
			frmPort <= '0;
			frmBadPort <= 1'b0;
			frmTagged <= 1'b0;
			frmVid <= '0;
			frmCand <= '0;
			frmMembers <= '0;
			scanIdx <= '0;
		end
		else
		begin
			case (state)
				vlan_filter_pkg::ST_IDLE:
				begin
					if (inValid && inReady)
					begin
						inReady <= 1'b0;
						frmMode <= mode;
						frmPort <= inPortOk ? inPort : '0;
						frmBadPort <= !inPortOk;
						frmTagged <= inTagged;
						frmVid <= next_frmVid;
						frmCand <= inCandidates;
						frmMembers <= '0;
						scanIdx <= '0;
						if (mode == vlan_filter_pkg::MODE_TAG)
							state <= vlan_filter_pkg::ST_SCAN;
						else
							state <= vlan_filter_pkg::ST_DONE;
					end
				end
				vlan_filter_pkg::ST_SCAN:
				begin
					if (tbl.scanValid && (tbl.scanVid == frmVid))
					begin
						frmMembers <= tbl.scanMembers;
						state <= vlan_filter_pkg::ST_DONE;
					end
					else if (scanIdx == vlan_filter_pkg::LAST_IDX)
						state <= vlan_filter_pkg::ST_DONE;
					else
						scanIdx <= scanIdx + 1'b1;
				end
				vlan_filter_pkg::ST_DONE:
				begin
					inReady <= 1'b1;
					state <= vlan_filter_pkg::ST_IDLE;
				end
				default:
				begin
					inReady <= 1'b1;
					state <= vlan_filter_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Ingress check: tagged frames need trunk or hybrid table membership
	always_comb
	begin
		if (frmTagged)
			ingressOk = (linkType[frmPort] != vlan_filter_pkg::LINK_ACCESS) &&
				frmMembers[frmPort];
		else
			ingressOk = isMember(linkType[frmPort], untagVid[frmPort],
				frmMembers[frmPort], frmVid);
	end

	genvar p;
	generate
		for (p = 0; p < NP; p++)
		begin : g_egress
			logic allowed;
			always_comb
			begin
				case (frmMode)
					vlan_filter_pkg::MODE_PORT:
						allowed = sameGroup[p];
					vlan_filter_pkg::MODE_TAG:
						allowed = isMember(linkType[p], untagVid[p],
							frmMembers[p], frmVid);
					default:
						allowed = 1'b1;
				endcase
			end
			// A frame never returns through its own ingress port
			assign egressOk[p] = frmCand[p] && allowed &&
				(frmPort != vlan_filter_pkg::PORT_W'(p));
		end
	endgenerate

	assign nextDrop = frmBadPort ||
		((frmMode == vlan_filter_pkg::MODE_TAG) && !ingressOk);

	// Decision outputs, one cycle pulse of outValid per frame
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			outValid <= 1'b0;
			outEgress <= '0;
			outVid <= '0;
			outDrop <= 1'b0;
		end
		else
		begin
			outValid <= (state == vlan_filter_pkg::ST_DONE);
			if (state == vlan_filter_pkg::ST_DONE)
			begin
				outEgress <= nextDrop ? '0 : egressOk;
				outVid <= (frmMode == vlan_filter_pkg::MODE_TAG) ?
					frmVid : '0;
				outDrop <= nextDrop;
			end
		end
	end
endmodule : vlan_membership_filter

// *** bench/vlan_filter_asserts.sv ***
// Concurrent checks on the VLAN filter's top-level ports.
// Assumes one core_clk domain and an async active-high reset.
`timescale 1ns/1ps
module vlan_filter_asserts (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regRdData,
	// Frame path
	input wire logic inValid,
	input wire logic inReady,
	input wire logic [3:0] inPort,
	input wire logic inTagged,
	input wire logic [11:0] inVid,
	input wire logic [9:0] inCandidates,
	input wire logic outValid,
	input wire logic [9:0] outEgress,
	input wire logic [11:0] outVid,
	input wire logic outDrop,
	input wire logic gvrpActive
);
	logic [1:0] modeReg;
	logic [1:0] mCap;
	logic [3:0] pCap;
	logic [9:0] cCap;
	logic wCtrl;
	logic wGvrp;
	logic take;
	assign wCtrl = regWrite && regAddr == 8'h00;
	assign wGvrp = wCtrl && regWrData[2];
	assign take = inValid && inReady;
	// Mirror of the mode; code 3 is refused, so it never lands here
	always_ff @(posedge core_clk or posedge reset)
		if (reset)
			modeReg <= 2'h0;
		else if (wCtrl && regWrData[1:0] != 2'h3)
			modeReg <= regWrData[1:0];
	// Mode is sampled per frame, so keep what held at the take edge
	always_ff @(posedge core_clk or posedge reset)
		if (reset)
			{mCap, pCap, cCap} <= 16'h0000;
		else if (take)
			{mCap, pCap, cCap} <= {modeReg, inPort, inCandidates};
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	chk_mode_readback:
		assert property (regRead && regAddr == 8'h00
			|=> regRdData[1:0] == $past(modeReg))
		else $error("mode readback differs");
	chk_disabled_all:
		assert property (outValid && mCap == 2'h0 && pCap < 4'hA
			|-> outEgress == (cCap & ~(10'h001 << pCap)) && !outDrop)
		else $error("disabled mode restricted forwarding");
	chk_port_latency:
		assert property (take && modeReg != 2'h2 |-> ##2 outValid)
		else $error("decision late outside tag mode");
	chk_tag_ignored:
		assert property (outValid && mCap != 2'h2 |-> outVid == 12'h000)
		else $error("VID reported outside tag mode");
	chk_table_scan:
		assert property (take && modeReg == 2'h2 |-> ##[3:259] outValid)
		else $error("table scan exceeded its bound");
	chk_gvrp_cause:
		assert property ($rose(gvrpActive) |->
			$past(wGvrp) || $past(wGvrp, 2))
		else $error("GVRP active without enabling write");
	chk_ready_busy:
		assert property (take |=> !inReady)
		else $error("descriptor taken while a decision is pending");
	chk_gvrp_off:
		assert property (wCtrl && regWrData[1:0] < 2'h2 |-> ##2 !gvrpActive)
		else $error("GVRP active outside tag mode");
	chk_drop_empty:
		assert property (outValid && outDrop |-> outEgress == 10'h000)
		else $error("dropped frame still has egress ports");
	chk_egress_subset:
		assert property (outValid
			|-> (outEgress & (~cCap | (10'h001 << pCap))) == 10'h000)
		else $error("egress outside candidates or on ingress");
	cover property (take && modeReg == 2'h2);
	cover property (outValid && outDrop);
	cover property ($rose(gvrpActive));
endmodule : vlan_filter_asserts

bind vlan_membership_filter vlan_filter_asserts chk (.core_clk(core_clk),
	.reset(reset), .regAddr(regAddr), .regWrData(regWrData),
	.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
	.inValid(inValid), .inReady(inReady), .inPort(inPort),
	.inTagged(inTagged), .inVid(inVid), .inCandidates(inCandidates),
	.outValid(outValid), .outEgress(outEgress), .outVid(outVid),
	.outDrop(outDrop), .gvrpActive(gvrpActive));

// *** bench/frame_source.sv ***
// Ingress side model: offers frame descriptors, collects decisions.
// Assumes a descriptor is taken on an edge with inReady high.
`timescale 1ns/1ps
module frame_source (
	// Clock
	input wire logic core_clk,
	// Descriptor out
	output logic inValid,
	input wire logic inReady,
	output logic [3:0] inPort,
	output logic inTagged,
	output logic [11:0] inVid,
	output logic [9:0] inCandidates,
	// Decision in
	input wire logic outValid,
	input wire logic [9:0] outEgress,
	input wire logic [11:0] outVid,
	input wire logic outDrop
);
	logic [9:0] eg;
	logic [11:0] vid;
	logic drop;
	logic late;
	initial
	begin
		inValid = 1'b0;
		{inPort, inTagged, inVid, inCandidates} = 27'h0;
	end
	task automatic send(input logic [3:0] p, input logic t,
		input logic [11:0] v, input logic [9:0] c);
		int n;
		n = 0;
		inValid <= 1'b1;
		{inPort, inTagged, inVid, inCandidates} <= {p, t, v, c};
		do @(posedge core_clk); while (!inReady);
		// Released lines show junk so a stale descriptor cannot help
		inValid <= 1'b0;
		{inPort, inTagged, inVid, inCandidates} <= ~{p, t, v, c};
		while (!outValid && n < 300)
		begin
			@(posedge core_clk);
			n++;
		end
		late = n == 300;
		{eg, vid, drop} = {outEgress, outVid, outDrop};
	endtask : send
endmodule : frame_source

// *** bench/vlan_membership_filter_tb_top.sv ***
// Self-checking bench: register traffic and frame decisions per mode.
// Assumes the handed-over register map and decision latencies.
`timescale 1ns/1ps
module vlan_membership_filter_tb_top;
	logic core_clk, reset, regWrite, regRead, gvrpActive;
	logic [7:0] regAddr;
	logic [31:0] regWrData, regRdData;
	logic inValid, inReady, inTagged, outValid, outDrop;
	logic [3:0] inPort;
	logic [11:0] inVid, outVid;
	logic [9:0] inCandidates, outEgress;
	int nMismatch = 0;
	int cmpCount = 0;
	int cyc = 0;
	vlan_membership_filter dut (.core_clk(core_clk), .reset(reset),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .inValid(inValid),
		.inReady(inReady), .inPort(inPort), .inTagged(inTagged),
		.inVid(inVid), .inCandidates(inCandidates), .outValid(outValid),
		.outEgress(outEgress), .outVid(outVid), .outDrop(outDrop),
		.gvrpActive(gvrpActive));
	frame_source src (.core_clk(core_clk), .inValid(inValid),
		.inReady(inReady), .inPort(inPort), .inTagged(inTagged),
		.inVid(inVid), .inCandidates(inCandidates), .outValid(outValid),
		.outEgress(outEgress), .outVid(outVid), .outDrop(outDrop));
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic close_out;
		$display("mismatches %0d compares %0d", nMismatch, cmpCount);
		if (nMismatch == 0 && cmpCount > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		{regWrite, regAddr, regWrData} <= {1'b1, a, d};
		@(posedge core_clk);
		regWrite <= 1'b0;
		// Idle edge, so a following write never sets the strobe twice at once
		@(posedge core_clk);
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		{regRead, regAddr} <= {1'b1, a};
		@(posedge core_clk);
		regRead <= 1'b0;
		@(posedge core_clk);
		cmp(regRdData, exp);
	endtask : rd
	task automatic gv(input logic x);
		repeat (2) @(posedge core_clk);
		cmp(32'(gvrpActive), 32'(x));
	endtask : gv
	task automatic fr(input logic [3:0] p, input logic t,
		input logic [11:0] v, input logic [9:0] c, input logic [9:0] e,
		input logic dr, input logic [11:0] vd);
		src.send(p, t, v, c);
		cmp(32'(src.late), 32'h0);
		cmp(32'(src.eg), 32'(e));
		cmp(32'(src.drop), 32'(dr));
		// A dropped frame's VID is left open, so only forwarded ones count
		if (!dr)
			cmp(32'(src.vid), 32'(vd));
	endtask : fr
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			nMismatch++;
			close_out;
		end
	end
	initial
	begin
		{reset, regWrite, regRead, regAddr, regWrData} = {3'b100, 40'h0};
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		rd(8'h00, 32'h0);
		fr(4'h2, 1'b0, 12'h000, 10'h3FF, 10'h3FB, 1'b0, 12'h000);
		wr(8'h00, 32'h5);
		gv(1'b0);
		wr(8'h00, 32'h3);
		rd(8'h00, 32'h1);
		for (int p = 0; p < 4; p++)
			wr(8'h40 + 8'(4 * p), 32'h0001_0001);
		fr(4'h1, 1'b1, 12'h007, 10'h3FF, 10'h00D, 1'b0, 12'h000);
		fr(4'h5, 1'b1, 12'h007, 10'h3FF, 10'h3D0, 1'b0, 12'h000);
		wr(8'h00, 32'h6);
		gv(1'b1);
		wr(8'h08, 32'h0);
		rd(8'h0C, 32'h803F_F001);
		wr(8'h0C, 32'h0);
		rd(8'h0C, 32'h803F_F001);
		rd(8'h04, 32'h1);
		wr(8'h04, 32'h1);
		wr(8'h64, 32'h3001);
		rd(8'h04, 32'h2);
		wr(8'h04, 32'h2);
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h64, 32'(i << 12) | 32'h1);
			rd(8'h64, 32'(i << 12) | 32'h1);
		end
		wr(8'h08, 32'hFF);
		wr(8'h0C, 32'h8000_0ABC);
		rd(8'h0C, 32'h8000_0ABC);
		wr(8'h08, 32'h5);
		wr(8'h0C, 32'h8001_3007);
		wr(8'h40, 32'h1007);
		wr(8'h48, 32'h0007);
		wr(8'h50, 32'h2001);
		wr(8'h44, 32'h0001);
		fr(4'h0, 1'b1, 12'h007, 10'h3FF, 10'h014, 1'b0, 12'h007);
		fr(4'h2, 1'b1, 12'h007, 10'h3FF, 10'h000, 1'b1, 12'h000);
		fr(4'h0, 1'b0, 12'h000, 10'h3FF, 10'h3FA, 1'b0, 12'h001);
		fr(4'h1, 1'b1, 12'h007, 10'h3FF, 10'h000, 1'b1, 12'h000);
		fr(4'h4, 1'b0, 12'h000, 10'h0F0, 10'h0E0, 1'b0, 12'h001);
		fr(4'h4, 1'b1, 12'hABC, 10'h3FF, 10'h000, 1'b1, 12'h000);
		wr(8'h00, 32'h4);
		gv(1'b0);
		fr(4'h9, 1'b1, 12'h007, 10'h3FF, 10'h1FF, 1'b0, 12'h000);
		close_out;
	end
endmodule : vlan_membership_filter_tb_top
